// ---- rtl/cfgsb_top.sv ----
// configuration register sideband outputs with apb access
//
// The APB interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "cfgsb_defs.svh"
// How it works
// - each two-way bus control pin is split into its own input port and output port with an enable.
// - cache_line always equals the held cache line-size register.
// - cmd_bits 0 and 1 follow command bits 0 and 1, the i/o and memory enables.
// - cmd_bits 2 follows command bit 2, the master enable, meaningless in target-only builds.
// - cmd_bits 3 follows command bit 4, the write-and-invalidate enable.
// - cmd_bits 4 follows command bit 6, the parity error response enable.
// - cmd_bits 5 follows command bit 8, the system error response enable.
// - cmd_bits 6 follows command bit 10, the interrupt disable.
// - stat_bits 0 follows status bit 8, data parity error reported.
// - stat_bits 1 and 2 follow status bits 11 and 12, target abort signalled and received.
// - stat_bits 3 follows status bit 13, master abort received.
// - stat_bits 4 and 5 follow status bits 14 and 15, system error signalled and parity error detected.
// - stat_bits 6 follows status bit 3, the interrupt status.
// - the interrupt line is pulled only while local logic requests it and interrupt disable is zero.
// - the parity error line is pulled on a data parity error only when parity response is enabled.
// - the system error line is pulled on an address parity error only when system error is enabled.
module cfgsb_top (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // core events and local interrupt request
  input wire logic data_par_err,
  input wire logic addr_par_err,
  input wire logic tabort_sig_ev,
  input wire logic tabort_rcvd_ev,
  input wire logic mabort_rcvd_ev,
  input wire logic local_irq_req_n,
  // split bus pins
  input wire logic perr_in_n,
  output logic perr_out_n,
  output logic perr_oe_n,
  input wire logic serr_in_n,
  output logic serr_out_n,
  output logic serr_oe_n,
  input wire logic inta_in_n,
  output logic inta_out_n,
  output logic inta_oe_n,
  // sideband outputs
  output logic [7:0] cache_line,
  output logic [6:0] cmd_bits,
  output logic [6:0] stat_bits,
  // interrupt
  output logic irq
);
  cfgsb_pkg::cfgsb_state_t st_r;
  cfgsb_pkg::cfgsb_state_t st_nxt;
  logic setup;
  logic access;
  logic wr;
  logic rd;
  logic hit;
  logic [15:0] stat_word;
  logic [5:0] pst_set;
  logic [5:0] pst_clr;
  logic [5:0] pst_q;
  logic [`CFGSB_NEV-1:0] ev_set;
  logic [`CFGSB_NEV-1:0] ev_clr;
  logic [`CFGSB_NEV-1:0] ev_q;
  logic perr_low;
  logic serr_low;
  logic inta_low;

  // apb phase decode
  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign wr = access & pwrite;
  assign rd = access & ~pwrite;
  assign hit = (paddr == `CFGSB_OFS_CMD) | (paddr == `CFGSB_OFS_STAT) | (paddr == `CFGSB_OFS_CACHE)
    | (paddr == `CFGSB_OFS_ISTAT) | (paddr == `CFGSB_OFS_IMASK);
  assign pready = 1'b1;
  assign pslverr = access & ~hit;

  // pci status word, write one to clear, hardware set wins
  always_comb
  begin
    stat_word = 16'h0000;
    stat_word[`CFGSB_ST_INT] = st_r.int_req;
    stat_word[`CFGSB_ST_PREP] = pst_q[0];
    stat_word[`CFGSB_ST_TASIG] = pst_q[1];
    stat_word[`CFGSB_ST_TARCV] = pst_q[2];
    stat_word[`CFGSB_ST_MARCV] = pst_q[3];
    stat_word[`CFGSB_ST_SSIG] = pst_q[4];
    stat_word[`CFGSB_ST_PDET] = pst_q[5];
  end

  // status event sources
  always_comb
  begin
    pst_set[0] = data_par_err & st_r.cmd[`CFGSB_CMD_PERR];
    pst_set[1] = tabort_sig_ev;
    pst_set[2] = tabort_rcvd_ev;
    pst_set[3] = mabort_rcvd_ev;
    pst_set[4] = addr_par_err & st_r.cmd[`CFGSB_CMD_SERR];
    pst_set[5] = data_par_err | addr_par_err;
    pst_clr = '0;
    if (wr && paddr == `CFGSB_OFS_STAT)
    begin
      pst_clr[0] = pwdata[`CFGSB_ST_PREP];
      pst_clr[1] = pwdata[`CFGSB_ST_TASIG];
      pst_clr[2] = pwdata[`CFGSB_ST_TARCV];
      pst_clr[3] = pwdata[`CFGSB_ST_MARCV];
      pst_clr[4] = pwdata[`CFGSB_ST_SSIG];
      pst_clr[5] = pwdata[`CFGSB_ST_PDET];
    end
  end

  cfgsb_sticky #(
    .W(6)
  ) u_pstat (
    .pclk(pclk),
    .presetn(presetn),
    .set(pst_set),
    .clr(pst_clr),
    .q(pst_q)
  );

  // interrupt events; a read clears only the bits it returned
  always_comb
  begin
    ev_set = '0;
    ev_set[`CFGSB_EV_DPAR] = data_par_err;
    ev_set[`CFGSB_EV_APAR] = addr_par_err;
    ev_set[`CFGSB_EV_TASIG] = tabort_sig_ev;
    ev_set[`CFGSB_EV_TARCV] = tabort_rcvd_ev;
    ev_set[`CFGSB_EV_MARCV] = mabort_rcvd_ev;
    ev_set[`CFGSB_EV_PERRL] = perr_low;
    ev_set[`CFGSB_EV_SERRL] = serr_low;
    ev_set[`CFGSB_EV_INTAL] = inta_low;
    ev_clr = '0;
    if (rd && paddr == `CFGSB_OFS_ISTAT)
      ev_clr = st_r.rdata[`CFGSB_NEV-1:0];
  end

  cfgsb_sticky #(
    .W(`CFGSB_NEV)
  ) u_istat (
    .pclk(pclk),
    .presetn(presetn),
    .set(ev_set),
    .clr(ev_clr),
    .q(ev_q)
  );

  assign irq = |(ev_q & st_r.imask);

  // register writes, read data captured in the setup cycle
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.int_req = ~local_irq_req_n;
    st_nxt.dpar = data_par_err;
    st_nxt.apar = addr_par_err;
    if (wr && paddr == `CFGSB_OFS_CMD)
      st_nxt.cmd = pwdata[15:0] & `CFGSB_CMD_WMASK;
    if (wr && paddr == `CFGSB_OFS_CACHE)
      st_nxt.cache = pwdata[7:0];
    if (wr && paddr == `CFGSB_OFS_IMASK)
      st_nxt.imask = pwdata[7:0];
    if (setup && !pwrite)
    begin
      case (paddr)
        `CFGSB_OFS_CMD: st_nxt.rdata = {16'h0000, st_r.cmd};
        `CFGSB_OFS_STAT: st_nxt.rdata = {16'h0000, stat_word};
        `CFGSB_OFS_CACHE: st_nxt.rdata = {24'h0000_00, st_r.cache};
        `CFGSB_OFS_ISTAT: st_nxt.rdata = {24'h0000_00, ev_q};
        `CFGSB_OFS_IMASK: st_nxt.rdata = {24'h0000_00, st_r.imask};
        default: st_nxt.rdata = 32'h0000_0000;
      endcase
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r <= '0;
      st_r.cmd <= `CFGSB_RST_CMD;
      st_r.cache <= `CFGSB_RST_CACHE;
      st_r.imask <= `CFGSB_RST_IMASK;
    end
    else
      st_r <= st_nxt;
  end

  assign prdata = st_r.rdata;

  // split bus pins
  cfgsb_pin u_perr (
    .pclk(pclk),
    .presetn(presetn),
    .assert_req(st_r.dpar & st_r.cmd[`CFGSB_CMD_PERR]),
    .pin_in_n(perr_in_n),
    .pin_out_n(perr_out_n),
    .pin_oe_n(perr_oe_n),
    .other_low(perr_low)
  );

  cfgsb_pin u_serr (
    .pclk(pclk),
    .presetn(presetn),
    .assert_req(st_r.apar & st_r.cmd[`CFGSB_CMD_SERR]),
    .pin_in_n(serr_in_n),
    .pin_out_n(serr_out_n),
    .pin_oe_n(serr_oe_n),
    .other_low(serr_low)
  );

  cfgsb_pin u_inta (
    .pclk(pclk),
    .presetn(presetn),
    .assert_req(st_r.int_req & ~st_r.cmd[`CFGSB_CMD_INTDIS]),
    .pin_in_n(inta_in_n),
    .pin_out_n(inta_out_n),
    .pin_oe_n(inta_oe_n),
    .other_low(inta_low)
  );

  // sideband outputs, straight from the held registers
  assign cache_line = st_r.cache;
  assign cmd_bits[0] = st_r.cmd[`CFGSB_CMD_IO];
  assign cmd_bits[1] = st_r.cmd[`CFGSB_CMD_MEM];
  assign cmd_bits[2] = st_r.cmd[`CFGSB_CMD_MSTR];
  assign cmd_bits[3] = st_r.cmd[`CFGSB_CMD_MWI];
  assign cmd_bits[4] = st_r.cmd[`CFGSB_CMD_PERR];
  assign cmd_bits[5] = st_r.cmd[`CFGSB_CMD_SERR];
  assign cmd_bits[6] = st_r.cmd[`CFGSB_CMD_INTDIS];
  assign stat_bits[0] = stat_word[`CFGSB_ST_PREP];
  assign stat_bits[1] = stat_word[`CFGSB_ST_TASIG];
  assign stat_bits[2] = stat_word[`CFGSB_ST_TARCV];
  assign stat_bits[3] = stat_word[`CFGSB_ST_MARCV];
  assign stat_bits[4] = stat_word[`CFGSB_ST_SSIG];
  assign stat_bits[5] = stat_word[`CFGSB_ST_PDET];
  assign stat_bits[6] = stat_word[`CFGSB_ST_INT];

  // checks
  chk_cache_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && paddr == `CFGSB_OFS_CACHE) |=> (cache_line == $past(pwdata[7:0])))
    else $error("cache line output did not take the write");
  chk_cmd_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && paddr == `CFGSB_OFS_CMD) |=> (cmd_bits[0] == $past(pwdata[0]) && cmd_bits[3] == $past(pwdata[4])
      && cmd_bits[6] == $past(pwdata[10])))
    else $error("command bits did not follow the write");
  chk_mem_enable: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && paddr == `CFGSB_OFS_CMD) |=> (cmd_bits[1] == $past(pwdata[1]) && cmd_bits[2] == $past(pwdata[2])))
    else $error("memory or master enable wrong");
  chk_err_enables: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && paddr == `CFGSB_OFS_CMD) |=> (cmd_bits[4] == $past(pwdata[6]) && cmd_bits[5] == $past(pwdata[8])))
    else $error("error response enables wrong");
  chk_inta_gate: assert property (@(posedge pclk) disable iff (!presetn)
    !inta_oe_n |-> ($past(~local_irq_req_n, 2) && $past(~cmd_bits[6])))
    else $error("interrupt pulled while not requested or disabled");
  chk_perr_gate: assert property (@(posedge pclk) disable iff (!presetn)
    (data_par_err && cmd_bits[4]) |=> ##1 (!perr_oe_n && stat_bits[0] && stat_bits[5]))
    else $error("parity error not signalled");
  chk_serr_gate: assert property (@(posedge pclk) disable iff (!presetn)
    !serr_oe_n |-> $past(addr_par_err, 2) && $past(cmd_bits[5]))
    else $error("system error pulled without cause");
  chk_abort_flags: assert property (@(posedge pclk) disable iff (!presetn)
    (tabort_sig_ev || tabort_rcvd_ev || mabort_rcvd_ev)
      |=> ((stat_bits[3:1] | ~$past({mabort_rcvd_ev, tabort_rcvd_ev, tabort_sig_ev})) == 3'b111))
    else $error("abort flags not set");
  chk_int_status: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 (stat_bits[6] == $past(~local_irq_req_n)))
    else $error("interrupt status does not follow request");
  chk_serr_status: assert property (@(posedge pclk) disable iff (!presetn)
    (addr_par_err && cmd_bits[5]) |=> (stat_bits[4] && stat_bits[5]))
    else $error("system error status not set");
  chk_pin_split: assert property (@(posedge pclk) disable iff (!presetn)
    (perr_out_n == 1'b0) && (serr_out_n == 1'b0) && (inta_out_n == 1'b0))
    else $error("open-drain output value not low");
  chk_foreign_low: assert property (@(posedge pclk) disable iff (!presetn)
    (perr_oe_n && !perr_in_n) |=> ##1 ev_q[`CFGSB_EV_PERRL])
    else $error("foreign low on the parity line not flagged");
  chk_cache_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr && paddr == `CFGSB_OFS_CACHE) |=> $stable(cache_line))
    else $error("cache line output changed without a write");
  chk_cmd_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr && paddr == `CFGSB_OFS_CMD) |=> $stable(cmd_bits))
    else $error("command bits changed without a write");
  chk_stat_rep: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(stat_bits[0]) |-> $past(data_par_err && cmd_bits[4]))
    else $error("parity reported flag set without an enabled data parity error");
  chk_perr_only: assert property (@(posedge pclk) disable iff (!presetn)
    !perr_oe_n |-> $past(data_par_err, 2) && $past(cmd_bits[4]))
    else $error("parity error line pulled without cause");
  chk_intdis_block: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_bits[6] |=> inta_oe_n)
    else $error("interrupt line pulled while disabled");
endmodule // cfgsb_top

// ---- rtl/cfgsb_defs.svh ----
// constants of the configuration sideband block
`ifndef CFGSB_DEFS_SVH
`define CFGSB_DEFS_SVH
// register byte offsets
`define CFGSB_OFS_CMD 12'h000
`define CFGSB_OFS_STAT 12'h004
`define CFGSB_OFS_CACHE 12'h008
`define CFGSB_OFS_ISTAT 12'h00C
`define CFGSB_OFS_IMASK 12'h010
// command register bit positions
`define CFGSB_CMD_IO 0
`define CFGSB_CMD_MEM 1
`define CFGSB_CMD_MSTR 2
`define CFGSB_CMD_MWI 4
`define CFGSB_CMD_PERR 6
`define CFGSB_CMD_SERR 8
`define CFGSB_CMD_INTDIS 10
`define CFGSB_CMD_WMASK 16'h0557
// status register bit positions
`define CFGSB_ST_INT 3
`define CFGSB_ST_PREP 8
`define CFGSB_ST_TASIG 11
`define CFGSB_ST_TARCV 12
`define CFGSB_ST_MARCV 13
`define CFGSB_ST_SSIG 14
`define CFGSB_ST_PDET 15
// interrupt event bit positions
`define CFGSB_EV_DPAR 0
`define CFGSB_EV_APAR 1
`define CFGSB_EV_TASIG 2
`define CFGSB_EV_TARCV 3
`define CFGSB_EV_MARCV 4
`define CFGSB_EV_PERRL 5
`define CFGSB_EV_SERRL 6
`define CFGSB_EV_INTAL 7
`define CFGSB_NEV 8
// reset values
`define CFGSB_RST_CMD 16'h0000
`define CFGSB_RST_CACHE 8'h00
`define CFGSB_RST_IMASK 8'h00
`endif

// ---- rtl/cfgsb_pkg.sv ----
// types of the configuration sideband block
package cfgsb_pkg;
  typedef struct packed {
    logic [15:0] cmd;
    logic [7:0] cache;
    logic [7:0] imask;
    logic [31:0] rdata;
    logic int_req;
    logic dpar;
    logic apar;
  } cfgsb_state_t;
  typedef struct packed {
    logic drive;
    logic other_low;
  } cfgsb_pin_t;
endpackage

// ---- rtl/cfgsb_sticky.sv ----
// sticky flag vector, set wins over clear
`timescale 1ns/1ps
module cfgsb_sticky #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // set and clear pulses
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] clr,
  // flags
  output logic [W-1:0] q
);
  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;
  // next value per bit
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      assign q_nxt[i] = set[i] | (q_r[i] & ~clr[i]);
    end
  endgenerate
  // flag register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      q_r <= '0;
    else
      q_r <= q_nxt;
  end
  assign q = q_r;
  chk_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
    (set != '0) |=> ((q_r & $past(set)) == $past(set)))
    else $error("sticky set was lost");
endmodule // cfgsb_sticky

// ---- rtl/cfgsb_pin.sv ----
// split open-drain bus pin: separate input, output and enable
`timescale 1ns/1ps
module cfgsb_pin (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // internal request to pull the line low
  input wire logic assert_req,
  // split pin
  input wire logic pin_in_n,
  output logic pin_out_n,
  output logic pin_oe_n,
  // line seen low while not driven by us
  output logic other_low
);
  cfgsb_pkg::cfgsb_pin_t st_r;
  cfgsb_pkg::cfgsb_pin_t st_nxt;
  // drive flag and foreign-low detection
  always_comb
  begin
    st_nxt.drive = assert_req;
    st_nxt.other_low = ~pin_in_n & ~st_r.drive;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end
  // open drain: value always low, enable low while pulling
  assign pin_out_n = 1'b0;
  assign pin_oe_n = ~st_r.drive;
  assign other_low = st_r.other_low;
endmodule // cfgsb_pin

// ---- bench/cfgsb_bus_model.sv ----
// wired open-drain bus lines with pull-ups and a foreign driver
`timescale 1ns/1ps
module cfgsb_bus_model (
  // our split pins
  input wire logic perr_out_n,
  input wire logic perr_oe_n,
  input wire logic serr_out_n,
  input wire logic serr_oe_n,
  input wire logic inta_out_n,
  input wire logic inta_oe_n,
  // another agent pulling a line low
  input wire logic pull_perr,
  input wire logic pull_serr,
  input wire logic pull_inta,
  // resolved line levels
  output logic perr_in_n,
  output logic serr_in_n,
  output logic inta_in_n
);
  // pull-up unless someone drives a low
  assign perr_in_n = (perr_oe_n | perr_out_n) & ~pull_perr;
  assign serr_in_n = (serr_oe_n | serr_out_n) & ~pull_serr;
  assign inta_in_n = (inta_oe_n | inta_out_n) & ~pull_inta;
endmodule // cfgsb_bus_model

// ---- bench/testbench.sv ----
// self-checking bench of the configuration sideband block
`timescale 1ns/1ps
`include "cfgsb_defs.svh"
module testbench;
  logic pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, lirq_n, pp, ps, pi;
  logic [4:0] ev;
  logic perr_in_n, perr_out_n, perr_oe_n, serr_in_n, serr_out_n, serr_oe_n;
  logic inta_in_n, inta_out_n, inta_oe_n, irq;
  logic [7:0] cache_line;
  logic [6:0] cmd_bits, stat_bits;
  int fails, cmp_count;
  cfgsb_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .data_par_err(ev[0]), .addr_par_err(ev[1]), .tabort_sig_ev(ev[2]), .tabort_rcvd_ev(ev[3]),
    .mabort_rcvd_ev(ev[4]), .local_irq_req_n(lirq_n), .perr_in_n(perr_in_n), .perr_out_n(perr_out_n),
    .perr_oe_n(perr_oe_n), .serr_in_n(serr_in_n), .serr_out_n(serr_out_n), .serr_oe_n(serr_oe_n),
    .inta_in_n(inta_in_n), .inta_out_n(inta_out_n), .inta_oe_n(inta_oe_n), .cache_line(cache_line),
    .cmd_bits(cmd_bits), .stat_bits(stat_bits), .irq(irq));
  cfgsb_bus_model i_bus (.perr_out_n(perr_out_n), .perr_oe_n(perr_oe_n), .serr_out_n(serr_out_n),
    .serr_oe_n(serr_oe_n), .inta_out_n(inta_out_n), .inta_oe_n(inta_oe_n), .pull_perr(pp),
    .pull_serr(ps), .pull_inta(pi), .perr_in_n(perr_in_n), .serr_in_n(serr_in_n),
    .inta_in_n(inta_in_n));
  // clock
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // verdict and end of run
  task automatic finish_test;
    begin
      if (fails == 0 && cmp_count > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    begin
      cmp_count++;
      if (seen !== exp)
      begin
        fails++;
        $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // wait edges, then let updates settle
  task automatic wt(input int k);
    begin
      repeat (k) @(posedge pclk);
      #1;
    end
  endtask
  // one apb transfer, waiting on pready with a bound
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
    output logic e);
    int n;
    begin
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
        @(posedge pclk);
        n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (n >= 20)
      begin
        fails++;
        finish_test();
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  // each command enable reaches its output bit
  task automatic t_cmd;
    int pos [7];
    logic [31:0] q;
    logic e;
    begin
      pos = '{0, 1, 2, 4, 6, 8, 10};
      for (int i = 0; i < 7; i++)
      begin
        apb(1'b1, `CFGSB_OFS_CMD, 32'h0000_0001 << pos[i], q, e);
        wt(0);
        chk(cmd_bits, 32'h0000_0001 << i);
        apb(1'b0, `CFGSB_OFS_CMD, 32'h0000_0000, q, e);
        chk(q, 32'h0000_0001 << pos[i]);
        chk(e, 32'h0000_0000);
      end
      apb(1'b1, `CFGSB_OFS_CMD, 32'hFFFF_FFFF, q, e);
      wt(0);
      chk(cmd_bits, 32'h0000_007F);
      apb(1'b1, `CFGSB_OFS_CACHE, 32'h0000_01A5, q, e);
      wt(0);
      chk(cache_line, 32'h0000_00A5);
    end
  endtask
  // events set status outputs; pins gated by enables
  task automatic t_events(input logic [15:0] cm);
    logic [6:0] ex [5];
    logic [31:0] q;
    logic e;
    begin
      ex = '{{2'b01, 4'h0, cm[6]}, {2'b01, cm[8], 4'h0}, 7'h02, 7'h04, 7'h08};
      apb(1'b1, `CFGSB_OFS_CMD, {16'h0000, cm}, q, e);
      for (int i = 0; i < 5; i++)
      begin
        @(posedge pclk);
        ev <= 5'h01 << i;
        @(posedge pclk);
        ev <= 5'h00;
        #1;
        chk(stat_bits, ex[i]);
        wt(1);
        chk(perr_oe_n, !(i == 0 && cm[6]));
        chk(serr_oe_n, !(i == 1 && cm[8]));
        apb(1'b1, `CFGSB_OFS_STAT, 32'h0000_F900, q, e);
        wt(0);
        chk(stat_bits, 32'h0000_0000);
      end
    end
  endtask
  // interrupt line, status flag and masked interrupt output
  task automatic t_irq;
    logic [31:0] q;
    logic e;
    begin
      apb(1'b1, `CFGSB_OFS_CMD, 32'h0000_0000, q, e);
      apb(1'b0, `CFGSB_OFS_ISTAT, 32'h0000_0000, q, e);
      apb(1'b1, `CFGSB_OFS_IMASK, 32'h0000_0020, q, e);
      @(posedge pclk);
      lirq_n <= 1'b0;
      wt(4);
      chk(inta_oe_n, 32'h0000_0000);
      chk(stat_bits, 32'h0000_0040);
      apb(1'b1, `CFGSB_OFS_CMD, 32'h0000_0400, q, e);
      wt(2);
      chk(inta_oe_n, 32'h0000_0001);
      chk(stat_bits, 32'h0000_0040);
      @(posedge pclk);
      lirq_n <= 1'b1;
      chk(irq, 32'h0000_0000);
      @(posedge pclk);
      pp <= 1'b1;
      @(posedge pclk);
      pp <= 1'b0;
      wt(3);
      chk(irq, 32'h0000_0001);
      apb(1'b0, `CFGSB_OFS_ISTAT, 32'h0000_0000, q, e);
      chk(q, 32'h0000_0020);
      wt(0);
      chk(irq, 32'h0000_0000);
      apb(1'b0, 12'h014, 32'h0000_0000, q, e);
      chk(e, 32'h0000_0001);
      chk(q, 32'h0000_0000);
    end
  endtask
  // main sequence
  initial
  begin
    fails = 0;
    cmp_count = 0;
    presetn = 1'b0;
    {psel, penable, pwrite, pp, ps, pi} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    ev = 5'h00;
    lirq_n = 1'b1;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    wt(1);
    chk({cache_line, cmd_bits, stat_bits, irq}, 32'h0000_0000);
    chk({perr_oe_n, serr_oe_n, inta_oe_n}, 32'h0000_0007);
    chk({perr_out_n, serr_out_n, inta_out_n}, 32'h0000_0000);
    t_cmd();
    t_events(16'h0140);
    t_events(16'h0000);
    t_irq();
    finish_test();
  end
endmodule // testbench
